// ---- design/ram_blk_pkg.sv ----
// shared constants, types and decode helpers of the small embedded ram block
// assumes a 32-bit apb register bus and one system clock
package ram_blk_pkg;

    localparam int DATA_W = 18;
    localparam int ADDR_W = 9;
    localparam int BYTES = 64;
    localparam int BUF_DEPTH = 16;
    // 576 bits with parity, 512 bits of plain data
    localparam logic [14:0] CAP_PAR = 15'h240;
    localparam logic [14:0] CAP_DATA = 15'h200;
    localparam logic [2:0] SHAPE_PAR_MIN = 3'h5;
    // allowed read/write pairs of plain shapes, bit [rd*5 + wr]
    localparam logic [24:0] PAIR_OK = 25'h175dfff;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] INIT_ADDR_OFS = 8'h08;
    localparam logic [7:0] INIT_DATA_OFS = 8'h0c;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    typedef enum logic [4:0] {
        MODE_SDP = 5'h01,
        MODE_SP = 5'h02,
        MODE_FIFO = 5'h04,
        MODE_ROM = 5'h08,
        MODE_SHIFT = 5'h10
    } mode_e;

    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic [2:0] tap_cnt;
        logic [8:0] tap_len;
        logic [1:0] rsvd_mid;
        logic rd_clk_b;
        logic wr_clk_b;
        logic out_reg;
        logic [2:0] rd_shape;
        logic [2:0] wr_shape;
        mode_e mode;
    } ctrl_s;

    typedef struct packed {
        logic [2:0] rsvd_hi;
        logic [8:0] shift_ptr;
        logic [1:0] rsvd_mid;
        logic [9:0] fill;
        logic [3:0] rsvd_lo;
        logic buf_full;
        logic mem_full;
        logic mem_empty;
        logic cfg_err;
    } stat_s;

    typedef struct packed {
        logic [8:0] addr;
        logic [17:0] data;
    } wr_req_s;

    function automatic logic [4:0] shape_width(input logic [2:0] s);
        case (s)
            3'h0: return 5'h01;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h3: return 5'h08;
            3'h4: return 5'h10;
            3'h5: return 5'h09;
            3'h6: return 5'h12;
            default: return 5'h00;
        endcase
    endfunction

    function automatic logic [9:0] shape_depth(input logic [2:0] s);
        case (s)
            3'h0: return 10'h200;
            3'h1: return 10'h100;
            3'h2: return 10'h080;
            3'h3: return 10'h040;
            3'h5: return 10'h040;
            default: return 10'h020;
        endcase
    endfunction

    function automatic logic [17:0] width_mask(input logic [5:0] w);
        logic [18:0] m;
        m = (19'h00001 << w) - 19'h00001;
        return m[17:0];
    endfunction

endpackage

// ---- design/req_buffer.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module req_buffer #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wp, rp, next_wp, next_rp;
    logic [PW:0] cnt, next_cnt;
    logic push, pop;

    assign in_ready_o = cnt != (PW+1)'(DEPTH);
    assign out_valid_o = cnt != '0;
    assign out_data_o = store[rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_wp = push ? PW'((int'(wp) + 1) % DEPTH) : wp;
        next_rp = pop ? PW'((int'(rp) + 1) % DEPTH) : rp;
        next_cnt = cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            store[wp] <= in_data_i;
        end
    end
endmodule

// ---- design/small_ram_block.sv ----
// small embedded ram block: 576 bits, five modes, mixed shapes, apb setup
// assumes block clock edges arrive as one-cycle ticks on clk_sys_i
//
// What this block does
// - shift writes old location, reads it first
// - shift addressing generated inside the block
// - 576 storage bits, parity bits included
// - dual-port, single-port, fifo, rom, shift modes
// - ram/rom contents preloadable from an image
// - shapes 512x1 to 32x16, parity 64x9/32x18
// - mixed widths per pair table, parity alike
// - write registers share one selected clock
// - read registers pick either block clock
// - only output register may be bypassed
// - input clear shows next edge, output now
// - same-address read during write gives old
// - single-port output shows newly written data
// - one parity bit position per byte
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module small_ram_block (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // block clock edges
    input wire logic clk_a_tick_i,
    input wire logic clk_b_tick_i,
    // write requests
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [8:0] wr_addr_i,
    input wire logic [17:0] wr_data_i,
    // read side and clears
    input wire logic rd_en_i,
    input wire logic [8:0] rd_addr_i,
    input wire logic in_clr_i,
    input wire logic out_clr_i,
    output logic [17:0] q_o
);
    // storage, 64 bytes of 9 bits
    logic [8:0] mem [ram_blk_pkg::BYTES];
    ram_blk_pkg::ctrl_s ctrl, next_ctrl;
    ram_blk_pkg::stat_s stat;
    ram_blk_pkg::wr_req_s item;
    logic [5:0] init_addr, next_init_addr;
    logic [31:0] next_prdata;
    logic [8:0] rd_addr, next_rd_addr, wp, next_wp, rp, next_rp, sptr, next_sptr;
    logic [17:0] q, next_q, raw, wr_d;
    logic [9:0] fill, next_fill, depth;
    logic [9:0] wloc [ram_blk_pkg::DATA_W];
    logic [4:0] ww, rw, wr_w, rd_w;
    logic [5:0] nw;
    logic [7:0] nw_wide;
    logic [8:0] wr_a, rd_a;
    logic wpar, rpar, rd_p, cfg_err, wr_tick, rd_tick, buf_valid;
    logic wr_go, do_wr, rd_go, shift, fifo, acc, mapped, init_wr;

    function automatic logic [9:0] bit_loc(input logic [8:0] a, input logic [4:0] k,
                                            input logic [4:0] w, input logic par);
        logic [13:0] idx;
        logic hi;
        idx = 14'(a) * 14'(w) + 14'(k);
        hi = k >= 5'h09;
        // parity layouts keep a ninth bit per byte
        if (par) begin
            return {6'(a * ((w == 5'h12) ? 9'h002 : 9'h001) + 9'(hi)),
                    hi ? 4'(k - 5'h09) : 4'(k)};
        end
        return {idx[8:3], 1'b0, idx[2:0]};
    endfunction

    function automatic logic [8:0] ptr_inc(input logic [8:0] p, input logic [9:0] lim);
        return (10'(p) + 10'h001 >= lim) ? 9'h000 : p + 9'h001;
    endfunction

    req_buffer #(
        .WIDTH($bits(ram_blk_pkg::wr_req_s)),
        .DEPTH(ram_blk_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .in_data_i({wr_addr_i, wr_data_i}),
        .out_valid_o(buf_valid),
        .out_ready_i(wr_go),
        .out_data_o(item)
    );

    // one clock for all write registers
    assign wr_tick = ctrl.wr_clk_b ? clk_b_tick_i : clk_a_tick_i;
    assign rd_tick = ctrl.rd_clk_b ? clk_b_tick_i : clk_a_tick_i;
    assign ww = ram_blk_pkg::shape_width(ctrl.wr_shape);
    assign rw = ram_blk_pkg::shape_width(ctrl.rd_shape);
    assign wpar = ctrl.wr_shape >= ram_blk_pkg::SHAPE_PAR_MIN;
    assign rpar = ctrl.rd_shape >= ram_blk_pkg::SHAPE_PAR_MIN;
    // product kept wide so an oversized tap setup cannot wrap into range
    assign nw_wide = 8'(ww) * 8'(ctrl.tap_cnt);
    assign nw = nw_wide[5:0];
    assign depth = ram_blk_pkg::shape_depth(ctrl.wr_shape);
    assign shift = ctrl.mode == ram_blk_pkg::MODE_SHIFT;
    assign fifo = ctrl.mode == ram_blk_pkg::MODE_FIFO;

    // a bad setup freezes both ports rather than corrupting contents
    always_comb begin
        cfg_err = ww == 5'h00 || rw == 5'h00;
        case (ctrl.mode)
            // mixed widths, parity shapes only pair alike
            ram_blk_pkg::MODE_SDP: begin
                if (wpar || rpar) begin
                    cfg_err = cfg_err || ctrl.rd_shape != ctrl.wr_shape;
                end else begin
                    cfg_err = cfg_err ||
                        !ram_blk_pkg::PAIR_OK[5'(ctrl.rd_shape) * 5'h05 + 5'(ctrl.wr_shape)];
                end
            end
            ram_blk_pkg::MODE_SP, ram_blk_pkg::MODE_FIFO, ram_blk_pkg::MODE_ROM: begin
                cfg_err = cfg_err || ctrl.rd_shape != ctrl.wr_shape;
            end
            ram_blk_pkg::MODE_SHIFT: begin
                cfg_err = cfg_err || nw_wide == 8'h00 || nw_wide > 8'h12 ||
                    ctrl.tap_len == 9'h000 ||
                    15'(ctrl.tap_len) * 15'(nw) >
                    (wpar ? ram_blk_pkg::CAP_PAR : ram_blk_pkg::CAP_DATA);
            end
            default: cfg_err = 1'b1;
        endcase
    end

    // old word read before it is overwritten
    always_comb begin
        logic [9:0] l;
        l = '0;
        rd_a = shift ? sptr : rd_addr;
        rd_w = shift ? nw[4:0] : rw;
        rd_p = shift ? wpar : rpar;
        raw = '0;
        for (int k = 0; k < ram_blk_pkg::DATA_W; k++) begin
            l = bit_loc(rd_a, 5'(k), rd_w, rd_p);
            raw[k] = (5'(k) < rd_w) ? mem[l[9:4]][l[3:0]] : 1'b0;
        end
    end

    always_comb begin
        wr_go = wr_tick && buf_valid && !cfg_err && !(fifo && fill == depth);
        do_wr = wr_go && ctrl.mode != ram_blk_pkg::MODE_ROM;
        case (ctrl.mode)
            ram_blk_pkg::MODE_FIFO: wr_a = wp;
            ram_blk_pkg::MODE_SHIFT: wr_a = sptr;
            default: wr_a = item.addr;
        endcase
        wr_w = shift ? nw[4:0] : ww;
        wr_d = shift ? ((raw << ww) | item.data) & ram_blk_pkg::width_mask(nw) : item.data;
        for (int k = 0; k < ram_blk_pkg::DATA_W; k++) begin
            wloc[k] = bit_loc(wr_a, 5'(k), wr_w, wpar);
        end
        rd_go = rd_tick && rd_en_i && !cfg_err && !shift && !(fifo && fill == 10'h000) &&
            !(ctrl.mode == ram_blk_pkg::MODE_SP && wr_go);
    end

    // write lands at the edge, so a same-cycle read sees old data
    always_ff @(posedge clk_sys_i) begin
        if (do_wr) begin
            for (int k = 0; k < ram_blk_pkg::DATA_W; k++) begin
                if (5'(k) < wr_w) begin
                    mem[wloc[k][9:4]][wloc[k][3:0]] <= wr_d[k];
                end
            end
        end
        if (init_wr) begin
            mem[init_addr] <= pwdata_i[8:0];
        end
    end

    always_comb begin
        next_rd_addr = rd_addr;
        next_wp = wp;
        next_rp = rp;
        next_fill = fill;
        next_sptr = sptr;
        next_q = q;
        if (rd_go) begin
            next_rd_addr = fifo ? rp : rd_addr_i;
        end
        // single-port reads back the written location
        if (ctrl.mode == ram_blk_pkg::MODE_SP && wr_go) begin
            next_rd_addr = item.addr;
        end
        if (fifo) begin
            next_wp = wr_go ? ptr_inc(wp, depth) : wp;
            next_rp = rd_go ? ptr_inc(rp, depth) : rp;
            next_fill = fill + 10'(wr_go) - 10'(rd_go);
        end
        if (shift && wr_go) begin
            next_sptr = ptr_inc(sptr, {1'b0, ctrl.tap_len});
            next_q = raw;
        end else if (rd_tick && !shift) begin
            next_q = raw;
        end
        // input clear reaches the output one edge later
        if (in_clr_i) begin
            next_rd_addr = '0;
            next_wp = '0;
            next_rp = '0;
            next_fill = '0;
            next_sptr = '0;
        end
        if (out_clr_i) begin
            next_q = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rd_addr <= '0;
            wp <= '0;
            rp <= '0;
            fill <= '0;
            sptr <= '0;
            q <= '0;
        end else begin
            rd_addr <= next_rd_addr;
            wp <= next_wp;
            rp <= next_rp;
            fill <= next_fill;
            sptr <= next_sptr;
            q <= next_q;
        end
    end

    // output clear acts at once; bypass leaves read path raw outside shift mode, which always uses q
    assign q_o = out_clr_i ? 18'h00000 : ((ctrl.out_reg || shift) ? q : raw);

    always_comb begin
        stat = '0;
        stat.cfg_err = cfg_err;
        stat.mem_empty = fill == 10'h000;
        stat.mem_full = fill == depth;
        stat.buf_full = !wr_ready_o;
        stat.fill = fill;
        stat.shift_ptr = sptr;
    end

    assign acc = psel_i && penable_i;
    assign mapped = paddr_i == ram_blk_pkg::CTRL_OFS || paddr_i == ram_blk_pkg::STAT_OFS ||
        paddr_i == ram_blk_pkg::INIT_ADDR_OFS || paddr_i == ram_blk_pkg::INIT_DATA_OFS;
    assign init_wr = acc && pwrite_i && paddr_i == ram_blk_pkg::INIT_DATA_OFS;
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped;

    // read data captured in the setup cycle, so it is stable for the access
    always_comb begin
        next_ctrl = ctrl;
        next_init_addr = init_addr;
        next_prdata = prdata_o;
        if (acc && pwrite_i && paddr_i == ram_blk_pkg::CTRL_OFS) begin
            next_ctrl = ram_blk_pkg::ctrl_s'(pwdata_i);
            next_ctrl.rsvd_hi = '0;
            next_ctrl.rsvd_mid = '0;
        end
        if (acc && pwrite_i && paddr_i == ram_blk_pkg::INIT_ADDR_OFS) begin
            next_init_addr = pwdata_i[5:0];
        end else if (init_wr) begin
            next_init_addr = init_addr + 6'h01;
        end
        if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                ram_blk_pkg::CTRL_OFS: next_prdata = ctrl;
                ram_blk_pkg::STAT_OFS: next_prdata = stat;
                ram_blk_pkg::INIT_ADDR_OFS: next_prdata = {26'h0, init_addr};
                ram_blk_pkg::INIT_DATA_OFS: next_prdata = {23'h0, mem[init_addr]};
                default: next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl <= ram_blk_pkg::ctrl_s'(ram_blk_pkg::CTRL_RST);
            init_addr <= '0;
            prdata_o <= '0;
        end else begin
            ctrl <= next_ctrl;
            init_addr <= next_init_addr;
            prdata_o <= next_prdata;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    sequence shift_step;
        shift && wr_go && !in_clr_i && !out_clr_i;
    endsequence

    shift_data_a: assert property (shift_step |=> q == $past(raw))
        else $error("shift output is not the old word");
    shift_ptr_a: assert property (shift_step |=>
        sptr == ptr_inc($past(sptr), {1'b0, $past(ctrl.tap_len)}))
        else $error("shift pointer did not advance");
    cfg_block_a: assert property (cfg_err |-> !wr_go && !rd_go)
        else $error("port active under bad shape setup");
    wr_clock_a: assert property (do_wr |-> buf_valid &&
        (ctrl.wr_clk_b ? clk_b_tick_i : clk_a_tick_i))
        else $error("write outside selected write clock");
    rd_clock_a: assert property ($changed(q) |->
        $past(rd_tick) || $past(out_clr_i) || $past(shift && wr_go))
        else $error("output register moved without read clock");
    rom_nowrite_a: assert property (ctrl.mode == ram_blk_pkg::MODE_ROM |-> !do_wr)
        else $error("rom mode wrote memory");
    init_write_a: assert property (init_wr |=> mem[$past(init_addr)] == $past(pwdata_i[8:0]))
        else $error("preload word not stored");
    in_clear_a: assert property (in_clr_i |=> rd_addr == 9'h000 && fill == 10'h000)
        else $error("input clear not applied at the edge");
    out_clear_a: assert property (out_clr_i |-> q_o == 18'h00000)
        else $error("output clear not immediate");
    sp_readback_a: assert property (
        ctrl.mode == ram_blk_pkg::MODE_SP && wr_go && !ctrl.out_reg && !in_clr_i && !init_wr
        |=> out_clr_i || q_o == ($past(item.data) & ram_blk_pkg::width_mask({1'b0, $past(ww)})))
        else $error("single-port output missed written data");
endmodule

// ---- sim/ram_user_model.sv ----
// user-logic model on the far side: write stream and block clock ticks
// assumes one system clock; the bench queues writes through push
`timescale 1ns/10ps
module ram_user_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // bench control
    input wire logic tick_en_i,
    // write stream
    input wire logic wr_ready_i,
    output logic wr_valid_o,
    output logic [8:0] wr_addr_o,
    output logic [17:0] wr_data_o,
    // block clock edges
    output logic clk_a_tick_o,
    output logic clk_b_tick_o
);
    ram_blk_pkg::wr_req_s pend[$];
    ram_blk_pkg::wr_req_s last;
    int seed = 35681;
    logic phase;

    task automatic push(input logic [8:0] a, input logic [17:0] d);
        pend.push_back({a, d});
    endtask

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wr_valid_o <= 1'b0;
            wr_addr_o <= 9'h000;
            wr_data_o <= 18'h00000;
            clk_a_tick_o <= 1'b0;
            clk_b_tick_o <= 1'b0;
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
            clk_a_tick_o <= tick_en_i & phase;
            clk_b_tick_o <= tick_en_i & ~phase;
            if (wr_valid_o && wr_ready_i) begin
                // released lines show the inverse, never the old request
                void'(pend.pop_front());
                wr_valid_o <= 1'b0;
                wr_addr_o <= ~last.addr;
                wr_data_o <= ~last.data;
            end else if (!wr_valid_o && pend.size() > 0 && $random(seed) % 3 != 0) begin
                wr_valid_o <= 1'b1;
                {wr_addr_o, wr_data_o} <= pend[0];
                last <= pend[0];
            end
        end
    end
endmodule

// ---- sim/small_ram_block_tb_top.sv ----
// self-checking bench of the small embedded ram block
// assumes the user model supplies ticks and the write stream
`timescale 1ns/10ps
module small_ram_block_tb_top;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q32;
    logic tick_a, tick_b, tick_en, wr_valid, wr_ready, rd_en, in_clr, out_clr;
    logic [8:0] wr_addr, rd_addr;
    logic [17:0] wr_data, q, q18;
    logic [7:0] d[20];
    logic [15:0] r;
    logic [8:0] p0, p1;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 35681;

    small_ram_block i_small_ram_block (.clk_sys_i(clk), .resetn_i(resetn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .clk_a_tick_i(tick_a),
        .clk_b_tick_i(tick_b), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .in_clr_i(in_clr), .out_clr_i(out_clr), .q_o(q));
    ram_user_model i_ram_user_model (.clk_sys_i(clk), .resetn_i(resetn), .tick_en_i(tick_en),
        .wr_ready_i(wr_ready), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .clk_a_tick_o(tick_a), .clk_b_tick_o(tick_b));

    always #2.5 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q32 = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cw(input ram_blk_pkg::mode_e md, input int ws,
        input int rs, input logic [8:0] m = 9'h000, input logic [2:0] n = 3'h0,
        input logic oreg = 1'b0, input logic rdb = 1'b0);
        ram_blk_pkg::ctrl_s c;
        c = '0;
        c.mode = md;
        c.wr_shape = 3'(ws);
        c.rd_shape = 3'(rs);
        c.tap_len = m;
        c.tap_cnt = n;
        c.out_reg = oreg;
        c.rd_clk_b = rdb;
        return c;
    endfunction

    task automatic cfg_chk(input logic [31:0] c, input logic e);
        apb(1'b1, ram_blk_pkg::CTRL_OFS, c);
        apb(1'b0, ram_blk_pkg::STAT_OFS, 32'h0);
        check("cfg_err", {31'h0, q32[0]}, {31'h0, e});
    endtask

    task automatic drain();
        while (i_ram_user_model.pend.size() != 0 || wr_valid) @(posedge clk);
        // two cycles per tick, sixteen queued entries at most
        repeat (40) @(posedge clk);
    endtask

    task automatic rd_q(input logic [8:0] a, input logic use_b, input int nt);
        rd_en <= 1'b1;
        rd_addr <= a;
        repeat (nt) do @(posedge clk); while ((use_b ? tick_b : tick_a) !== 1'b1);
        @(posedge clk);
        rd_en <= 1'b0;
        #1 q18 = q;
    endtask

    initial begin
        {clk, resetn, psel, penable, pwrite, rd_en, in_clr, out_clr} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rd_addr = 9'h000;
        tick_en = 1'b1;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, ram_blk_pkg::CTRL_OFS, 32'h0);
        check("ctrl reset", q32, ram_blk_pkg::CTRL_RST);
        apb(1'b1, 8'h10, 32'hffff_ffff);
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped data", q32, 32'h0);
        $display("test registers done");

        for (int s = 0; s < 7; s++) cfg_chk(cw(ram_blk_pkg::MODE_SDP, s, s), 1'b0);
        for (int i = 1; i < 4; i++) cfg_chk(cw(ram_blk_pkg::mode_e'(5'h01 << i), 3, 3), 1'b0);
        cfg_chk(cw(ram_blk_pkg::MODE_SDP, 3, 2), 1'b1);
        cfg_chk(cw(ram_blk_pkg::MODE_SDP, 5, 6), 1'b1);
        cfg_chk(cw(ram_blk_pkg::MODE_SHIFT, 3, 3, 9'h028, 3'h2), 1'b1);
        cfg_chk(cw(ram_blk_pkg::MODE_SHIFT, 3, 3, 9'h002, 3'h3), 1'b1);
        cfg_chk(cw(ram_blk_pkg::MODE_SHIFT, 6, 6, 9'h001, 3'h4), 1'b1);
        $display("test configurations done");

        r = 16'($random(seed));
        cfg_chk(cw(ram_blk_pkg::MODE_SDP, 0, 4, 9'h000, 3'h0, 1'b0, 1'b1), 1'b0);
        for (int k = 0; k < 16; k++) i_ram_user_model.push(9'(48 + k), {17'h0, r[k]});
        drain();
        rd_q(9'h003, 1'b1, 1);
        check("mixed width", {16'h0, q18[15:0]}, {16'h0, r});
        $display("test mixed width done");

        cfg_chk(cw(ram_blk_pkg::MODE_SDP, 3, 3), 1'b0);
        @(posedge clk);
        tick_en <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            d[i] = 8'($random(seed));
            i_ram_user_model.push(9'(i), {10'h0, d[i]});
        end
        for (int t = 0; t < 300 && wr_ready !== 1'b0; t++) @(posedge clk);
        check("ready full", {31'h0, wr_ready}, 32'h0);
        apb(1'b0, ram_blk_pkg::STAT_OFS, 32'h0);
        check("buffer full", {31'h0, q32[3]}, 32'h1);
        tick_en <= 1'b1;
        drain();
        check("ready drained", {31'h0, wr_ready}, 32'h1);
        rd_q(9'h011, 1'b0, 1);
        check("buffered write", {24'h0, q18[7:0]}, {24'h0, d[17]});
        $display("test buffer done");

        cfg_chk(cw(ram_blk_pkg::MODE_SP, 3, 3), 1'b0);
        i_ram_user_model.push(9'h005, {10'h0, d[3]});
        drain();
        #1 check("single port", {24'h0, q[7:0]}, {24'h0, d[3]});
        $display("test single port done");

        p0 = 9'($random(seed));
        p1 = 9'($random(seed));
        apb(1'b1, ram_blk_pkg::INIT_ADDR_OFS, 32'd62);
        apb(1'b1, ram_blk_pkg::INIT_DATA_OFS, {23'h0, p0});
        apb(1'b1, ram_blk_pkg::INIT_DATA_OFS, {23'h0, p1});
        apb(1'b1, ram_blk_pkg::INIT_ADDR_OFS, 32'd62);
        apb(1'b0, ram_blk_pkg::INIT_DATA_OFS, 32'h0);
        check("preload byte", q32, {23'h0, p0});
        cfg_chk(cw(ram_blk_pkg::MODE_SDP, 6, 6, 9'h000, 3'h0, 1'b1), 1'b0);
        rd_q(9'h01f, 1'b0, 2);
        check("preload word", {14'h0, q18}, {14'h0, p1, p0});
        @(posedge clk);
        out_clr <= 1'b1;
        #1 check("out clear", {14'h0, q}, 32'h0);
        @(posedge clk);
        out_clr <= 1'b0;
        $display("test preload done");

        cfg_chk(cw(ram_blk_pkg::MODE_SHIFT, 3, 3, 9'h002, 3'h1), 1'b0);
        for (int i = 0; i < 5; i++) i_ram_user_model.push(9'h000, {10'h0, d[i]});
        drain();
        check("shift tap", {24'h0, q[7:0]}, {24'h0, d[2]});
        apb(1'b0, ram_blk_pkg::STAT_OFS, 32'h0);
        check("shift ptr", {23'h0, q32[28:20]}, 32'h1);
        in_clr <= 1'b1;
        @(posedge clk);
        in_clr <= 1'b0;
        apb(1'b0, ram_blk_pkg::STAT_OFS, 32'h0);
        check("input clear", {23'h0, q32[28:20]}, 32'h0);
        $display("test shift done");

        // fifo on write clock b, stream addresses ignored
        cfg_chk(cw(ram_blk_pkg::MODE_FIFO, 3, 3) | 32'h0000_1000, 1'b0);
        for (int i = 5; i < 8; i++) i_ram_user_model.push(9'h1ff, {10'h0, d[i]});
        drain();
        rd_q(9'h000, 1'b0, 1);
        check("fifo head", {24'h0, q18[7:0]}, {24'h0, d[5]});
        apb(1'b0, ram_blk_pkg::STAT_OFS, 32'h0);
        check("fifo fill", {22'h0, q32[17:8]}, 32'h2);
        cfg_chk(cw(ram_blk_pkg::MODE_ROM, 3, 3), 1'b0);
        i_ram_user_model.push(9'h000, {10'h0, ~d[5]});
        drain();
        rd_q(9'h000, 1'b0, 1);
        check("rom keeps", {24'h0, q18[7:0]}, {24'h0, d[5]});
        $display("test fifo and rom done");
        tally_and_finish();
    end
endmodule
